// ==== design/scan_pkg.sv ====
// Functional notes
// R1: boundary scan runs only when scan select is high; low selects processor debug.
// R2: instructions SAMPLE, EXTEST and BYPASS behave as in the test-access standard.
// R3: in debug mode the data path returns a non-standard processor identification value.
// R4: tester must apply chip reset after changing scan select; no live switch.
// R5: pin scan chain is 484 cells between test data in and test data out.
// R6: each bidirectional pin owns input, output and control cells.
// R7: in external test the output cell drives the pad when control enables it.
// R8: input cell captures the pad level for shifting out.
// R9: control cell chooses between driving the pad and leaving it as input.
// R10: fixed layout, highest bit first; data line zero at 456, 455, 454.
// R11: tester drives mode select; tap state machine advances on test clock edges.
// R12: tester, not the device, generates the test clock at any rate; the code samples it on mclk through two flops, so it must run slower than mclk.
// R13: internal positions are plain shift cells without pads.
package scan_pkg;

  // ----------------------------------------
  // chain and instruction register
  // ----------------------------------------
  localparam int CHAIN_LEN = 484;
  localparam int IR_LEN = 4;
  localparam logic [3:0] IR_EXTEST = 4'h0;
  localparam logic [3:0] IR_SAMPLE = 4'h1;
  localparam logic [3:0] IR_BYPASS = 4'hF;
  localparam logic [3:0] IR_CAPTURE = 4'h1;
  localparam int ID_LEN = 32;
  // arbitrary value; bit 0 low marks it as not standard format
  localparam logic [31:0] DEBUG_ID_DEFAULT = 32'h5A5A_C3C2;

  // ----------------------------------------
  // pad layout: data lines 0..15 then address 18..22
  // ----------------------------------------
  localparam int NPAD = 21;
  localparam int NO_CELL = -1;
  localparam int PAD_IN_POS [NPAD] = '{456, 452, 449, 446, 443, 439, 436, 433, 430, 426, 423, 420, 417, 413,
                                       410, 407, -1, -1, -1, -1, -1};
  localparam int PAD_OUT_POS [NPAD] = '{455, 451, 448, 445, 442, 438, 435, 432, 429, 425, 422, 419, 416, 412,
                                        409, 406, 483, 481, 480, 479, 478};
  localparam int PAD_CTL_POS [NPAD] = '{454, 450, 447, 444, 441, 437, 434, 431, 428, 424, 421, 418, 415, 411,
                                        408, 405, 482, 482, 482, 482, 482};

  // ----------------------------------------
  // tap states
  // ----------------------------------------
  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR, TAP_PAUSE_DR, TAP_EXIT2_DR,
    TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SHIFT_IR, TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
  } tap_state_t;

endpackage

// ==== design/pin_sync_if.sv ====
`timescale 1ns/1ps
interface pin_sync_if #(parameter int NPAD = 21);
  logic tck;
  logic tms;
  logic tdi;
  logic trst_n;
  logic sel;
  logic [NPAD-1:0] pad;
  modport prod (output tck, tms, tdi, trst_n, sel, pad);
  modport cons (input tck, tms, tdi, trst_n, sel, pad);
endinterface

// ==== design/pin_sync.sv ====
`timescale 1ns/1ps
module pin_sync #(
  parameter int NPAD = 21
) (
  // clock
  input wire logic mclk,
  // raw pins
  input wire logic tck_raw,
  input wire logic tms_raw,
  input wire logic tdi_raw,
  input wire logic trst_n_raw,
  input wire logic sel_raw,
  input wire logic [NPAD-1:0] pad_raw,
  // synchronised side
  pin_sync_if.prod s
);
  // ----------------------------------------
  // two-flop synchronisers
  // ----------------------------------------
  logic [NPAD+4:0] meta_r;
  logic [NPAD+4:0] stab_r;

  always_ff @(posedge mclk) begin
    meta_r <= {pad_raw, sel_raw, trst_n_raw, tdi_raw, tms_raw, tck_raw};
    stab_r <= meta_r;
  end

  assign s.tck = stab_r[0];
  assign s.tms = stab_r[1];
  assign s.tdi = stab_r[2];
  assign s.trst_n = stab_r[3];
  assign s.sel = stab_r[4];
  assign s.pad = stab_r[NPAD+4:5];
endmodule

// ==== design/boundary_scan_chain.sv ====
`timescale 1ns/1ps
module boundary_scan_chain #(
  parameter logic [31:0] DEBUG_ID = scan_pkg::DEBUG_ID_DEFAULT
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // test port
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic test_logic_reset_n,
  input wire logic scan_select_pin,
  output logic tdo,
  output logic tdo_oe,
  // pads
  input wire logic [scan_pkg::NPAD-1:0] pad_i,
  output logic [scan_pkg::NPAD-1:0] pad_o,
  output logic [scan_pkg::NPAD-1:0] pad_oe,
  // core side
  input wire logic [scan_pkg::NPAD-1:0] core_o,
  input wire logic [scan_pkg::NPAD-1:0] core_oe,
  output logic [scan_pkg::NPAD-1:0] core_i,
  // status
  output logic bscan_mode
);
  localparam int N = scan_pkg::NPAD;
  localparam int L = scan_pkg::CHAIN_LEN;

  // ----------------------------------------
  // pin synchronisation
  // ----------------------------------------
  pin_sync_if #(.NPAD(N)) s ();

  pin_sync #(.NPAD(N)) u_sync (
    .mclk(mclk),
    .tck_raw(tck),
    .tms_raw(tms),
    .tdi_raw(tdi),
    .trst_n_raw(test_logic_reset_n),
    .sel_raw(scan_select_pin),
    .pad_raw(pad_i),
    .s(s.prod)
  );

  assign core_i = s.pad;

  // ----------------------------------------
  // test clock edge detection
  // ----------------------------------------
  logic tck_prev_r;
  logic tck_rise;
  logic tck_fall;

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      tck_prev_r <= 1'b0;
    end else begin
      tck_prev_r <= s.tck;
    end
  end

  assign tck_rise = s.tck & ~tck_prev_r; // see R12
  assign tck_fall = ~s.tck & tck_prev_r;

  // ----------------------------------------
  // mode caught during chip reset
  // ----------------------------------------
  logic bscan_r;

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      bscan_r <= s.sel; // see R1 see R4
    end
  end

  assign bscan_mode = bscan_r;

  // ----------------------------------------
  // tap state machine
  // ----------------------------------------
  scan_pkg::tap_state_t state_r;
  scan_pkg::tap_state_t state_nxt;

  always_comb begin
    case (state_r)
      scan_pkg::TAP_RESET: state_nxt = s.tms ? scan_pkg::TAP_RESET : scan_pkg::TAP_IDLE;
      scan_pkg::TAP_IDLE: state_nxt = s.tms ? scan_pkg::TAP_SEL_DR : scan_pkg::TAP_IDLE;
      scan_pkg::TAP_SEL_DR: state_nxt = s.tms ? scan_pkg::TAP_SEL_IR : scan_pkg::TAP_CAP_DR;
      scan_pkg::TAP_CAP_DR: state_nxt = s.tms ? scan_pkg::TAP_EXIT1_DR : scan_pkg::TAP_SHIFT_DR;
      scan_pkg::TAP_SHIFT_DR: state_nxt = s.tms ? scan_pkg::TAP_EXIT1_DR : scan_pkg::TAP_SHIFT_DR;
      scan_pkg::TAP_EXIT1_DR: state_nxt = s.tms ? scan_pkg::TAP_UPD_DR : scan_pkg::TAP_PAUSE_DR;
      scan_pkg::TAP_PAUSE_DR: state_nxt = s.tms ? scan_pkg::TAP_EXIT2_DR : scan_pkg::TAP_PAUSE_DR;
      scan_pkg::TAP_EXIT2_DR: state_nxt = s.tms ? scan_pkg::TAP_UPD_DR : scan_pkg::TAP_SHIFT_DR;
      scan_pkg::TAP_UPD_DR: state_nxt = s.tms ? scan_pkg::TAP_SEL_DR : scan_pkg::TAP_IDLE;
      scan_pkg::TAP_SEL_IR: state_nxt = s.tms ? scan_pkg::TAP_RESET : scan_pkg::TAP_CAP_IR;
      scan_pkg::TAP_CAP_IR: state_nxt = s.tms ? scan_pkg::TAP_EXIT1_IR : scan_pkg::TAP_SHIFT_IR;
      scan_pkg::TAP_SHIFT_IR: state_nxt = s.tms ? scan_pkg::TAP_EXIT1_IR : scan_pkg::TAP_SHIFT_IR;
      scan_pkg::TAP_EXIT1_IR: state_nxt = s.tms ? scan_pkg::TAP_UPD_IR : scan_pkg::TAP_PAUSE_IR;
      scan_pkg::TAP_PAUSE_IR: state_nxt = s.tms ? scan_pkg::TAP_EXIT2_IR : scan_pkg::TAP_PAUSE_IR;
      scan_pkg::TAP_EXIT2_IR: state_nxt = s.tms ? scan_pkg::TAP_UPD_IR : scan_pkg::TAP_SHIFT_IR;
      scan_pkg::TAP_UPD_IR: state_nxt = s.tms ? scan_pkg::TAP_SEL_DR : scan_pkg::TAP_IDLE;
      default: state_nxt = scan_pkg::TAP_RESET;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_b || !s.trst_n) begin
      state_r <= scan_pkg::TAP_RESET;
    end else if (tck_rise) begin
      state_r <= state_nxt; // see R11
    end
  end

  // ----------------------------------------
  // instruction register
  // ----------------------------------------
  logic [scan_pkg::IR_LEN-1:0] ir_sh_r;
  logic [scan_pkg::IR_LEN-1:0] ir_r;

  always_ff @(posedge mclk) begin
    if (!rst_b || !s.trst_n) begin
      ir_sh_r <= '0;
      ir_r <= scan_pkg::IR_BYPASS;
    end else if (tck_rise) begin
      case (state_r)
        scan_pkg::TAP_RESET: ir_r <= scan_pkg::IR_BYPASS;
        scan_pkg::TAP_CAP_IR: ir_sh_r <= scan_pkg::IR_CAPTURE;
        scan_pkg::TAP_SHIFT_IR: ir_sh_r <= {s.tdi, ir_sh_r[scan_pkg::IR_LEN-1:1]};
        scan_pkg::TAP_UPD_IR: ir_r <= ir_sh_r; // see R2
        default: ir_r <= ir_r;
      endcase
    end
  end

  logic sel_chain;
  logic extest;

  assign sel_chain = bscan_r && (ir_r == scan_pkg::IR_EXTEST || ir_r == scan_pkg::IR_SAMPLE); // see R2
  assign extest = bscan_r && ir_r == scan_pkg::IR_EXTEST;

  // ----------------------------------------
  // pin scan chain capture values
  // ----------------------------------------
  logic [L-1:0] chain_r;
  logic [L-1:0] upd_r;
  logic [L-1:0] cap_val;

  always_comb begin
    cap_val = chain_r; // see R13
    for (int i = 0; i < N; i++) begin
      if (scan_pkg::PAD_IN_POS[i] != scan_pkg::NO_CELL) begin
        cap_val[scan_pkg::PAD_IN_POS[i]] = s.pad[i]; // see R8
      end
      cap_val[scan_pkg::PAD_OUT_POS[i]] = core_o[i];
      cap_val[scan_pkg::PAD_CTL_POS[i]] = core_oe[i];
    end
  end

  // ----------------------------------------
  // data registers
  // ----------------------------------------
  logic byp_r;
  logic [scan_pkg::ID_LEN-1:0] id_r;

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      chain_r <= '0;
      upd_r <= '0;
      byp_r <= 1'b0;
      id_r <= '0;
    end else if (tck_rise) begin
      case (state_r)
        scan_pkg::TAP_CAP_DR: begin
          if (sel_chain) begin
            chain_r <= cap_val;
          end
          byp_r <= 1'b0;
          id_r <= DEBUG_ID; // see R3
        end
        scan_pkg::TAP_SHIFT_DR: begin
          if (sel_chain) begin
            chain_r <= {s.tdi, chain_r[L-1:1]}; // see R5 see R10
          end
          byp_r <= s.tdi;
          id_r <= {s.tdi, id_r[scan_pkg::ID_LEN-1:1]};
        end
        scan_pkg::TAP_UPD_DR: begin
          if (sel_chain) begin
            upd_r <= chain_r;
          end
        end
        default: byp_r <= byp_r;
      endcase
    end
  end

  // ----------------------------------------
  // test data out on falling test clock
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      tdo <= 1'b0;
      tdo_oe <= 1'b0;
    end else if (tck_fall) begin
      tdo_oe <= state_r == scan_pkg::TAP_SHIFT_DR || state_r == scan_pkg::TAP_SHIFT_IR;
      if (state_r == scan_pkg::TAP_SHIFT_IR) begin
        tdo <= ir_sh_r[0];
      end else if (!bscan_r) begin
        tdo <= id_r[0]; // see R3
      end else if (sel_chain) begin
        tdo <= chain_r[0]; // see R5
      end else begin
        tdo <= byp_r; // see R2
      end
    end
  end

  // ----------------------------------------
  // pad drive
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      pad_o <= '0;
      pad_oe <= '0;
    end else begin
      for (int i = 0; i < N; i++) begin
        if (extest) begin
          pad_oe[i] <= upd_r[scan_pkg::PAD_CTL_POS[i]]; // see R9 see R6
          pad_o[i] <= upd_r[scan_pkg::PAD_OUT_POS[i]]; // see R7
        end else begin
          pad_oe[i] <= core_oe[i];
          pad_o[i] <= core_o[i];
        end
      end
    end
  end
endmodule

// ==== dv/boundary_scan_chain_asserts.sv ====
`timescale 1ns/1ps
module boundary_scan_chain_asserts (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // test port
  input wire logic tck,
  input wire logic test_logic_reset_n,
  input wire logic tdo,
  input wire logic tdo_oe,
  input wire logic bscan_mode,
  // pads and core
  input wire logic [scan_pkg::NPAD-1:0] pad_i,
  input wire logic [scan_pkg::NPAD-1:0] pad_o,
  input wire logic [scan_pkg::NPAD-1:0] pad_oe,
  input wire logic [scan_pkg::NPAD-1:0] core_o,
  input wire logic [scan_pkg::NPAD-1:0] core_oe,
  input wire logic [scan_pkg::NPAD-1:0] core_i
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);
  a_reset_quiet: assert property ($rose(rst_b) |-> !tdo && !tdo_oe && pad_o == '0 && pad_oe == '0)
    else $error("outputs active out of reset");
  a_mode_hold: assert property ($past(rst_b) |-> $stable(bscan_mode))
    else $error("mode changed without reset");
  a_debug_pad_o: assert property (!bscan_mode |=> pad_o == $past(core_o))
    else $error("debug mode pad data not from core");
  a_debug_pad_oe: assert property (!bscan_mode |=> pad_oe == $past(core_oe))
    else $error("debug mode pad enable not from core");
  a_core_in: assert property ($past(rst_b, 2) |-> core_i == $past(pad_i, 2))
    else $error("core input not pad level");
  a_tdo_fall: assert property ($changed(tdo) || $changed(tdo_oe) |-> !tck)
    else $error("data out moved while test clock high");
  a_tdo_stands: assert property (tck && $past(tck) |-> $stable(tdo))
    else $error("data out unstable in high phase");
  a_trst_follow: assert property (!test_logic_reset_n [*6] |=> pad_o == $past(core_o) && pad_oe == $past(core_oe))
    else $error("test reset did not give pads to core");
endmodule
bind boundary_scan_chain boundary_scan_chain_asserts chk (.mclk, .rst_b, .tck, .test_logic_reset_n, .tdo, .tdo_oe,
  .bscan_mode, .pad_i, .pad_o, .pad_oe, .core_o, .core_oe, .core_i);

// ==== dv/scan_tester.sv ====
`timescale 1ns/1ps
module scan_tester (
  // pins
  input wire logic mclk,
  input wire logic tdo,
  output logic tck,
  output logic tms,
  output logic tdi,
  // captured data out
  output logic got,
  output logic seen
);
  initial {tck, tms, tdi, got, seen} = 5'h00;
  // one 80 ns test clock; it rests low between calls
  task automatic step(input logic m, input logic dv, input logic w);
    tms = m;
    tdi = dv;
    repeat (4) @(posedge mclk);
    #1 tck = 1'b1;
    seen = tdo;
    got = w;
    repeat (4) @(posedge mclk);
    #1 tck = 1'b0;
    got = 1'b0;
  endtask
endmodule

// ==== dv/boundary_scan_chain_bench.sv ====
`timescale 1ns/1ps
module boundary_scan_chain_bench;
  logic mclk, rst_b, trst_n, sel, tck, tms, tdi, tdo, tdo_oe, bscan_mode, got, seen;
  logic [scan_pkg::NPAD-1:0] pad_i, pad_o, pad_oe, core_o, core_oe, core_i;
  logic [483:0] ch, d;
  logic [7:0] r = 8'h3C;
  logic q[$];
  int failures, n_tests, cyc;
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  boundary_scan_chain dut (.mclk(mclk), .rst_b(rst_b), .tck(tck), .tms(tms), .tdi(tdi),
    .test_logic_reset_n(trst_n), .scan_select_pin(sel), .tdo(tdo), .tdo_oe(tdo_oe), .pad_i(pad_i),
    .pad_o(pad_o), .pad_oe(pad_oe), .core_o(core_o), .core_oe(core_oe), .core_i(core_i), .bscan_mode(bscan_mode));
  scan_tester tst (.mclk(mclk), .tdo(tdo), .tck(tck), .tms(tms), .tdi(tdi), .got(got), .seen(seen));
  task automatic final_report();
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic check(input logic [31:0] v, input logic [31:0] e);
    n_tests++;
    if (v !== e) begin
      failures++;
      $display("[FAIL] %0t got %h want %h", $time, v, e);
    end
  endtask
  always @(posedge got) begin
    check(seen, q.pop_front());
    check(tdo_oe, 1'b1);
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      final_report();
    end
  end
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  task automatic reset(input logic s);
    rst_b = 1'b0;
    sel = s;
    repeat (3) @(posedge mclk);
    #1 rst_b = 1'b1;
    repeat (3) @(posedge mclk);
    #1 tst.step(0, 0, 0);
  endtask
  // from idle through capture, shift, update, back to idle
  task automatic scan(input logic ir, input int n, input logic [483:0] dv, input logic [483:0] ex);
    tst.step(1, 0, 0);
    if (ir) tst.step(1, 0, 0);
    tst.step(0, 0, 0);
    tst.step(0, 0, 0);
    for (int i = 0; i < n; i++) begin
      q.push_back(ex[i]);
      tst.step(i == n - 1, dv[i], 1);
    end
    tst.step(1, 0, 0);
    tst.step(0, 0, 0);
  endtask
  task automatic shake();
    for (int i = 0; i < 484; i++) begin
      r = lfsr(r);
      d[i] = r[0];
      if (i < scan_pkg::NPAD) {pad_i[i], core_o[i], core_oe[i]} = r[3:1];
    end
    core_oe[20:16] = {5{core_oe[16]}};
  endtask
  task automatic run();
    logic [483:0] ex;
    ex = ch; // unpadded cells keep their bits
    for (int i = 0; i < scan_pkg::NPAD; i++) begin
      if (scan_pkg::PAD_IN_POS[i] >= 0) ex[scan_pkg::PAD_IN_POS[i]] = pad_i[i];
      ex[scan_pkg::PAD_OUT_POS[i]] = core_o[i];
      ex[scan_pkg::PAD_CTL_POS[i]] = core_oe[i];
    end
    scan(0, 484, d, ex);
    ch = d;
  endtask
  task automatic pads(input logic ext);
    logic [scan_pkg::NPAD-1:0] eo, ee;
    eo = core_o;
    ee = core_oe;
    for (int i = 0; i < scan_pkg::NPAD; i++) if (ext) begin
      eo[i] = ch[scan_pkg::PAD_OUT_POS[i]];
      ee[i] = ch[scan_pkg::PAD_CTL_POS[i]];
    end
    check(pad_o, eo);
    check(pad_oe, ee);
  endtask
  initial begin
    trst_n = 1'b1;
    {pad_i, core_o, core_oe} = '0;
    ch = '0;
    d = '0;
    reset(1'b0);
    check(bscan_mode, 0);
    scan(0, 32, 0, scan_pkg::DEBUG_ID_DEFAULT);
    reset(1'b1);
    check(bscan_mode, 1);
    scan(1, 4, scan_pkg::IR_BYPASS, scan_pkg::IR_CAPTURE);
    scan(0, 8, 8'hA5, {8'hA5, 1'b0});
    scan(1, 4, scan_pkg::IR_SAMPLE, scan_pkg::IR_CAPTURE);
    shake();
    run();
    pads(0);
    scan(1, 4, scan_pkg::IR_EXTEST, scan_pkg::IR_CAPTURE);
    pads(1);
    shake();
    run();
    pads(1);
    sel = 1'b0;
    repeat (4) @(posedge mclk);
    #1 check(bscan_mode, 1);
    trst_n = 1'b0;
    shake();
    repeat (8) @(posedge mclk);
    #1 pads(0);
    check(tdo_oe, 1'b0);
    trst_n = 1'b1;
    check(q.size(), 0);
    final_report();
  end
endmodule
